// file: hdl/tph_pkg.sv
// What this block does
// - Mask bit 7 enables haptic short interrupt
// - Mask bit 6 enables near object interrupt
// - Mask bit 5 enables far/proximity done
// - Mask bit 4 enables compensation done
// - Mask bit 3 enables pen/touch; resets 1
// - Mask bit 2 enables pen up interrupt
// - Mask bits 1,0 enable thermal warn/alarm
// - Source 7 sets on short rising edge
// - Source 6 sets when object becomes near
// - Source 5: far edge or proximity done
// - Source 4 sets when compensation finishes
// - Source 3: pen down or touch done
// - Source 2 sets when pen lifts
// - Source 1: selected thermal warn edge
// - Source 0: selected thermal alarm edge
// - Status 7 shows live haptic short
// - Status 6 latches that reset occurred
// - Status read clears reset latch
// - Near status gated, frozen while pen down
// - Conversion running; falling edge ends conversion
package tph_pkg;

    // Register offsets on the host port
    localparam logic [7:0] MASK_ADDR = 8'h22;
    localparam logic [7:0] SRC_ADDR = 8'h23;
    localparam logic [7:0] STAT_ADDR = 8'h24;
    localparam logic [7:0] CFG_ADDR = 8'h30;

    // Values after reset
    localparam logic [7:0] MASK_RESET = 8'h08;
    localparam logic [7:0] SRC_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // Bit positions shared by mask, source and status
    localparam int BIT_HAPTIC = 7;
    localparam int BIT_NEAR = 6;
    localparam int BIT_FAR = 5;
    localparam int BIT_COMP = 4;
    localparam int BIT_PEN_DOWN = 3;
    localparam int BIT_PEN_UP = 2;
    localparam int BIT_WARN = 1;
    localparam int BIT_ALARM = 0;

    // Status word positions where they differ from the source layout
    localparam int STAT_RESET_SEEN = 6;
    localparam int STAT_NEAR_NOW = 5;
    localparam int STAT_COMP_NOW = 4;
    localparam int STAT_CONV_NOW = 3;
    localparam int STAT_PEN_NOW = 2;

    // Configuration register positions
    localparam int CFG_PROX_SEL = 0;
    localparam int CFG_PEN_DETECT = 1;
    localparam int CFG_WARN_EDGE = 2;
    localparam int CFG_ALARM_EDGE = 3;

    // Live sense lines from the analog and sequencing logic
    typedef struct packed {
        logic hapticShort;
        logic objectNear;
        logic proximityEnable;
        logic compPending;
        logic touchConvBusy;
        logic proxConvBusy;
        logic penDown;
        logic thermalWarn;
        logic thermalAlarm;
    } tph_sense_type;

endpackage

// file: hdl/tph_irq_unit.sv
`timescale 1ns/10ps
`default_nettype none
module tph_irq_unit (
    input wire logic mclk, // System clock, 10 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire logic [7:0] regAddr, // Register address
    input wire logic [7:0] regWdata, // Register write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    output logic [7:0] regRdata, // Read data, valid the cycle after regRd
    input wire tph_pkg::tph_sense_type sense, // Live sense lines
    output logic irqReq // Interrupt request, active high
);

    // Rising and falling edge helpers, used for every source
    function automatic logic rose(input logic now, input logic was);
        rose = now & ~was;
    endfunction

    function automatic logic fell(input logic now, input logic was);
        fell = ~now & was;
    endfunction

    // Register state
    logic [7:0] mask_r;
    logic [7:0] mask_nxt;
    logic [7:0] src_r;
    logic [7:0] src_nxt;
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    logic resetSeen_r;
    logic resetSeen_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic irq_r;
    logic irq_nxt;

    // Conditioned status and history
    logic objectNearNow_r;
    logic objectNearNow_nxt;
    logic convRunning_r;
    logic convKindProx_r;
    logic convKindProx_nxt;
    logic [7:0] prevLive_r;
    logic [7:0] liveNow;
    logic [7:0] statusWord;
    logic [7:0] events;

    // Address decode
    wire hitMask = (regAddr == tph_pkg::MASK_ADDR);
    wire hitSrc = (regAddr == tph_pkg::SRC_ADDR);
    wire hitStat = (regAddr == tph_pkg::STAT_ADDR);
    wire hitCfg = (regAddr == tph_pkg::CFG_ADDR);
    wire wrMask = regWr & hitMask;
    wire wrCfg = regWr & hitCfg;
    wire rdSrc = regRd & hitSrc;
    wire rdStat = regRd & hitStat;

    // Configuration fields
    wire proximityIntSelect = cfg_r[tph_pkg::CFG_PROX_SEL];
    wire penDetectMode = cfg_r[tph_pkg::CFG_PEN_DETECT];
    wire thermalWarnEdgeSelect = cfg_r[tph_pkg::CFG_WARN_EDGE];
    wire thermalAlarmEdgeSelect = cfg_r[tph_pkg::CFG_ALARM_EDGE];

    // Near status: gated by enable, held while the pen is down so a hand on
    // the panel does not flicker the proximity flags
    assign objectNearNow_nxt = sense.penDown ? objectNearNow_r
                             : (sense.objectNear & sense.proximityEnable);

    // Conversion running covers both kinds; kind is remembered so the
    // falling edge can be attributed to the conversion that just ended
    wire convRunningNow = sense.touchConvBusy | sense.proxConvBusy;
    assign convKindProx_nxt = convRunningNow ? sense.proxConvBusy : convKindProx_r;

    // Live word in source bit order, compared against last cycle
    assign liveNow = {sense.hapticShort, objectNearNow_r, objectNearNow_r,
                      sense.compPending, sense.penDown, sense.penDown,
                      sense.thermalWarn, sense.thermalAlarm};

    // Conversion end events
    wire convEnded = fell(convRunningNow, convRunning_r);
    wire proxConvDone = convEnded & convKindProx_r;
    wire touchConvDone = convEnded & ~convKindProx_r;

    // Per-source edge events
    assign events[tph_pkg::BIT_HAPTIC] =
        rose(liveNow[tph_pkg::BIT_HAPTIC], prevLive_r[tph_pkg::BIT_HAPTIC]);
    assign events[tph_pkg::BIT_NEAR] =
        rose(liveNow[tph_pkg::BIT_NEAR], prevLive_r[tph_pkg::BIT_NEAR]);
    assign events[tph_pkg::BIT_FAR] = proximityIntSelect ? proxConvDone
        : fell(liveNow[tph_pkg::BIT_FAR], prevLive_r[tph_pkg::BIT_FAR]);
    assign events[tph_pkg::BIT_COMP] =
        fell(liveNow[tph_pkg::BIT_COMP], prevLive_r[tph_pkg::BIT_COMP]);
    assign events[tph_pkg::BIT_PEN_DOWN] = penDetectMode
        ? rose(liveNow[tph_pkg::BIT_PEN_DOWN], prevLive_r[tph_pkg::BIT_PEN_DOWN])
        : touchConvDone;
    assign events[tph_pkg::BIT_PEN_UP] =
        fell(liveNow[tph_pkg::BIT_PEN_UP], prevLive_r[tph_pkg::BIT_PEN_UP]);
    assign events[tph_pkg::BIT_WARN] = thermalWarnEdgeSelect
        ? fell(liveNow[tph_pkg::BIT_WARN], prevLive_r[tph_pkg::BIT_WARN])
        : rose(liveNow[tph_pkg::BIT_WARN], prevLive_r[tph_pkg::BIT_WARN]);
    assign events[tph_pkg::BIT_ALARM] = thermalAlarmEdgeSelect
        ? fell(liveNow[tph_pkg::BIT_ALARM], prevLive_r[tph_pkg::BIT_ALARM])
        : rose(liveNow[tph_pkg::BIT_ALARM], prevLive_r[tph_pkg::BIT_ALARM]);

    // Source flags: a read clears them, but an edge in the same cycle is
    // OR-ed in after the clear so it survives to the next read
    assign src_nxt = (rdSrc ? tph_pkg::SRC_RESET : src_r) | events;

    // Mask and configuration are plain read/write; the mask gates each
    // flag onto the request line, bit for bit
    assign mask_nxt = wrMask ? regWdata : mask_r;
    assign cfg_nxt = wrCfg ? regWdata : cfg_r;

    // Reset latch only ever sets through reset itself, so a read just clears
    assign resetSeen_nxt = rdStat ? 1'b0 : resetSeen_r;

    // Status word: live short, latched reset, then conditioned live lines
    assign statusWord = {sense.hapticShort, resetSeen_r, objectNearNow_r,
                         sense.compPending, convRunning_r, sense.penDown,
                         sense.thermalWarn, sense.thermalAlarm};

    // Read mux, sampled value before any clear of the same cycle
    assign rdata_nxt = !regRd ? rdata_r
                     : hitMask ? mask_r
                     : hitSrc ? src_r
                     : hitStat ? statusWord
                     : hitCfg ? cfg_r
                     : tph_pkg::UNMAPPED_DATA;

    // Request follows enabled flags; registered so it stays glitch free
    assign irq_nxt = |(src_nxt & mask_nxt);

    // Host-visible registers; mask resets with only the pen/touch bit set
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mask_r <= tph_pkg::MASK_RESET;
            src_r <= tph_pkg::SRC_RESET;
            cfg_r <= tph_pkg::CFG_RESET;
            resetSeen_r <= 1'b1;
        end else begin
            mask_r <= mask_nxt;
            src_r <= src_nxt;
            cfg_r <= cfg_nxt;
            resetSeen_r <= resetSeen_nxt;
        end
    end

    // Edge history; reset history is all low so a line already high at
    // release raises its rising-edge flag in the first cycle, the registered near flag in the second
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prevLive_r <= 8'h00;
            objectNearNow_r <= 1'b0;
            convRunning_r <= 1'b0;
            convKindProx_r <= 1'b0;
        end else begin
            prevLive_r <= liveNow;
            objectNearNow_r <= objectNearNow_nxt;
            convRunning_r <= convRunningNow;
            convKindProx_r <= convKindProx_nxt;
        end
    end

    // Outputs from flip-flops
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
            irq_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign regRdata = rdata_r;
    assign irqReq = irq_r;

endmodule
`default_nettype wire

// file: verif/tph_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module tph_host_model (
    input wire logic mclk, // System clock
    output logic [7:0] regAddr = 8'h00, // Address
    output logic [7:0] regWdata = 8'h00, // Write data
    output logic regWr = 1'b0, // Write strobe
    output logic regRd = 1'b0, // Read strobe
    input wire logic [7:0] regRdata // Read data
);
    // One-cycle write; signals move only just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        #1;
    endtask
    // Read data lands in the cycle after the strobe and holds until the next read, so take it there
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        v = regRdata;
    endtask
endmodule
`default_nettype wire

// file: verif/tph_irq_unit_sva.sv
`timescale 1ns/10ps
`default_nettype none
module tph_irq_unit_sva (
    input wire logic mclk, // Clock
    input wire logic rst, // Reset
    input wire logic [7:0] regAddr, // Address
    input wire logic [7:0] regWdata, // Write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    input wire logic [7:0] regRdata, // Read data
    input wire tph_pkg::tph_sense_type sense, // Sense lines
    input wire logic irqReq // Interrupt request
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic [7:0] maskSh_r;
    logic statRead_r;
    wire rdSrc = regRd && regAddr == tph_pkg::SRC_ADDR;
    wire rdStat = regRd && regAddr == tph_pkg::STAT_ADDR;
    wire wrMask = regWr && regAddr == tph_pkg::MASK_ADDR;
    // Shadow mask and first status read, so checks need no peek inside
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            maskSh_r <= tph_pkg::MASK_RESET;
            statRead_r <= 1'b0;
        end else begin
            maskSh_r <= wrMask ? regWdata : maskSh_r;
            statRead_r <= statRead_r | rdStat;
        end
    end
    property p_mask_rd;
        regRd && regAddr == tph_pkg::MASK_ADDR |=> regRdata == $past(maskSh_r);
    endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("mask read wrong");
    property p_gate;
        maskSh_r == 8'h00 |-> !irqReq;
    endproperty
    a_gate: assert property (p_gate) else $error("irq with mask clear");
    property p_short;
        $rose(sense.hapticShort) && maskSh_r[7] && !wrMask |=> irqReq;
    endproperty
    a_short: assert property (p_short) else $error("short irq missing");
    property p_pen_up;
        $fell(sense.penDown) && maskSh_r[2] && !wrMask |=> irqReq;
    endproperty
    a_pen_up: assert property (p_pen_up) else $error("pen up irq missing");
    property p_short_now;
        rdStat |=> regRdata[7] == $past(sense.hapticShort);
    endproperty
    a_short_now: assert property (p_short_now) else $error("live short wrong");
    property p_latch;
        rdStat && !statRead_r |=> regRdata[6];
    endproperty
    a_latch: assert property (p_latch) else $error("reset latch not set");
    property p_latch_clr;
        rdStat ##2 rdStat |=> !regRdata[6];
    endproperty
    a_latch_clr: assert property (p_latch_clr) else $error("latch not cleared");
    property p_src_clr;
        $stable(sense)[*2] ##1 (rdSrc && $stable(sense)) ##1 $stable(sense)
            ##1 (rdSrc && $stable(sense)) |=> regRdata == 8'h00;
    endproperty
    a_src_clr: assert property (p_src_clr) else $error("source not cleared");
    c_irq: cover property ($rose(irqReq));
    c_unmapped: cover property (regRd && regAddr > 8'h30);
    c_latch: cover property (rdStat ##1 regRdata[6]);
endmodule
bind tph_irq_unit tph_irq_unit_sva SVA (.mclk(mclk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .sense(sense), .irqReq(irqReq));
`default_nettype wire

// file: verif/tph_irq_unit_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin nMismatch++; \
    $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module tph_irq_unit_test;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr, regWdata, regRdata, d;
    logic regWr, regRd, irqReq;
    tph_pkg::tph_sense_type sense = '0;
    int nMismatch = 0;
    int compares = 0;
    // Edge tables: config, level before, level after, flag expected
    logic [7:0] cfgT [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h02, 8'h04, 8'h08};
    logic [8:0] frT [10] = '{9'h000, 9'h040, 9'h0C0, 9'h020, 9'h010, 9'h008, 9'h000, 9'h004,
        9'h002, 9'h001};
    logic [8:0] toT [10] = '{9'h002, 9'h0C0, 9'h040, 9'h000, 9'h000, 9'h000, 9'h004, 9'h000,
        9'h000, 9'h000};
    logic [7:0] exT [10] = '{8'h02, 8'h40, 8'h20, 8'h10, 8'h08, 8'h20, 8'h08, 8'h04, 8'h02, 8'h01};
    always #50 mclk = ~mclk;
    tph_irq_unit DUT (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sense(sense), .irqReq(irqReq));
    tph_host_model HOST (.mclk(mclk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata));
    // Sense lines settle a few cycles so registered near status has landed
    task sets(input logic [8:0] v);
        @(posedge mclk);
        sense <= tph_pkg::tph_sense_type'(v);
        repeat (4) @(posedge mclk);
    endtask
    task t_reset;
        HOST.rd(tph_pkg::MASK_ADDR, d); `CHK(d, 8'h08)
        HOST.rd(tph_pkg::SRC_ADDR, d); `CHK(d, 8'h00)
        HOST.rd(tph_pkg::SRC_ADDR, d); `CHK(d, 8'h00)
        HOST.rd(tph_pkg::STAT_ADDR, d); `CHK(d[6], 1'b1)
        HOST.rd(tph_pkg::STAT_ADDR, d); `CHK(d[6], 1'b0)
        HOST.rd(8'hA5, d); `CHK(d, 8'h00)
    endtask
    // Masked event stays latched, then raises the request once enabled
    task t_mask;
        HOST.wr(tph_pkg::MASK_ADDR, 8'h00);
        sets(9'h100); `CHK(irqReq, 1'b0)
        HOST.rd(tph_pkg::STAT_ADDR, d); `CHK(d[7], 1'b1)
        HOST.wr(tph_pkg::SRC_ADDR, 8'hFF);
        HOST.wr(tph_pkg::MASK_ADDR, 8'hFF); `CHK(irqReq, 1'b1)
        HOST.rd(tph_pkg::SRC_ADDR, d); `CHK(d, 8'h80)
        `CHK(irqReq, 1'b0)
        sets(9'h000);
        sets(9'h100); `CHK(irqReq, 1'b1)
        HOST.rd(tph_pkg::MASK_ADDR, d); `CHK(d, 8'hFF)
        sets(9'h000);
    endtask
    task t_events;
        for (int i = 0; i < 10; i++) begin
            HOST.wr(tph_pkg::CFG_ADDR, cfgT[i]);
            sets(frT[i]);
            HOST.rd(tph_pkg::SRC_ADDR, d);
            sets(toT[i]); `CHK(irqReq, 1'b1)
            HOST.rd(tph_pkg::SRC_ADDR, d); `CHK(d, exT[i])
        end
    endtask
    task print_verdict;
        $display("Mismatches %0d, compares %0d", nMismatch, compares);
        if (nMismatch == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_mask();
        t_events();
        print_verdict();
    end
    // Whole run is well under a thousand cycles
    initial begin
        #400000;
        nMismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
